/* rtl/bfi_top.sv */
// Bit-field insert unit with APB register access.
// Assumes an APB master on pclk; all operands are held in registers here.
//
// Overview of operation
// RQ1: An execution loads the base word into the result and then overwrites only the field.
// RQ2: The field starts at the source low position (0-31) and spans a length of 1-32 bits.
// RQ3: The field lands in the result with its lowest bit at the destination position (0-31).
// RQ4: Field bits that pass bit 31 of the result are dropped and never wrap.
// RQ5: Execution changes only the result and status flags, never the source or base words.
// RQ6: With exec_request low no operation runs and the result holds.
// RQ7: An enabled normal execution sets both the request and ack flags and inserts on the same clock edge.
// RQ8: Prescan, postscan and a low exec_request clear both the request and ack flags.
// RQ9: 8-bit and 16-bit operands are zero-filled to 32 bits before the insert.
// RQ10: The result is computed combinationally from registered operands and registered on go.
module bfi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] result_word,
  output logic exec_request_flag,
  output logic exec_ack
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [31:0] src_q, src_d;
  logic [31:0] base_q, base_d;
  logic [21:0] field_q, field_d;
  logic [31:0] result_q, result_d;
  logic req_flag_q, req_flag_d;
  logic ack_q, ack_d;
  logic err_q, err_d;

  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic go;
  logic go_run;
  logic go_idle;
  logic err_clr;
  logic params_ok;
  logic [5:0] src_pos;
  logic [5:0] fld_len;
  logic [5:0] dst_pos;
  bfi_pkg::bfi_phase_t phase;
  logic [31:0] base_sel;
  logic [31:0] src_ext;
  logic [31:0] base_ext;
  logic [31:0] core_result;

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      bfi_pkg::OFF_CTRL, bfi_pkg::OFF_SRC, bfi_pkg::OFF_BASE, bfi_pkg::OFF_FIELD,
      bfi_pkg::OFF_CMD, bfi_pkg::OFF_STATUS, bfi_pkg::OFF_RESULT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Read-back mux; a read never disturbs the register it shows
  function automatic logic [31:0] read_word(input logic [7:0] a);
    case (a)
      bfi_pkg::OFF_CTRL: return {24'h00_0000, ctrl_q};
      bfi_pkg::OFF_SRC: return src_q;
      bfi_pkg::OFF_BASE: return base_q;
      bfi_pkg::OFF_FIELD: return {10'h000, field_q};
      bfi_pkg::OFF_STATUS: return {29'h0000_0000, err_q, ack_q, req_flag_q};
      bfi_pkg::OFF_RESULT: return result_q;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign access = psel && penable;
  assign mapped = addr_mapped(paddr);
  assign pslverr = access && !mapped;
  assign wr = access && pwrite && mapped;
  assign rd = access && !pwrite && mapped;

  assign src_pos = field_q[bfi_pkg::FLD_SRCPOS_LSB +: bfi_pkg::FLD_SUB_W];
  assign fld_len = field_q[bfi_pkg::FLD_LEN_LSB +: bfi_pkg::FLD_SUB_W];
  assign dst_pos = field_q[bfi_pkg::FLD_DSTPOS_LSB +: bfi_pkg::FLD_SUB_W];
  assign phase = bfi_pkg::bfi_phase_t'(ctrl_q[bfi_pkg::CTRL_PHASE_LSB +: 2]);

  // Out-of-range operands are refused rather than silently wrapped
  assign params_ok = (src_pos <= bfi_pkg::POS_MAX) && (dst_pos <= bfi_pkg::POS_MAX) &&
                     (fld_len >= bfi_pkg::LEN_MIN) && (fld_len <= bfi_pkg::LEN_MAX); // RQ2 RQ3

  assign go = wr && (paddr == bfi_pkg::OFF_CMD) && pwdata[bfi_pkg::CMD_GO_BIT];
  assign go_run = go && ctrl_q[bfi_pkg::CTRL_REQ_BIT] && (phase == bfi_pkg::PH_NORMAL); // RQ7
  assign go_idle = go && !go_run; // RQ8
  assign err_clr = wr && (paddr == bfi_pkg::OFF_STATUS) && pwdata[bfi_pkg::STAT_ERR_BIT];

  // In-place mode reuses the current result as the base word
  assign base_sel = ctrl_q[bfi_pkg::CTRL_INPLACE_BIT] ? result_q : base_q;

  bfi_field_core u_core (
    .src_word(src_q),
    .base_word(base_sel),
    .src_width(ctrl_q[bfi_pkg::CTRL_SRCW_LSB +: 2]),
    .base_width(ctrl_q[bfi_pkg::CTRL_BASEW_LSB +: 2]),
    .src_low_pos(src_pos[4:0]),
    .dst_low_pos(dst_pos[4:0]),
    .field_len(fld_len),
    .src_ext(src_ext),
    .base_ext(base_ext),
    .result(core_result)
  );

  // Operand and control registers
  always_comb begin
    ctrl_d = ctrl_q;
    src_d = src_q;
    base_d = base_q;
    field_d = field_q;
    if (wr) begin
      case (paddr)
        bfi_pkg::OFF_CTRL: ctrl_d = pwdata[bfi_pkg::CTRL_W-1:0];
        bfi_pkg::OFF_SRC: src_d = pwdata;
        bfi_pkg::OFF_BASE: base_d = pwdata;
        bfi_pkg::OFF_FIELD: begin
          field_d = {pwdata[bfi_pkg::FLD_DSTPOS_LSB +: bfi_pkg::FLD_SUB_W], 2'b00,
                     pwdata[bfi_pkg::FLD_LEN_LSB +: bfi_pkg::FLD_SUB_W], 2'b00,
                     pwdata[bfi_pkg::FLD_SRCPOS_LSB +: bfi_pkg::FLD_SUB_W]};
        end
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= bfi_pkg::CTRL_RESET;
      src_q <= bfi_pkg::WORD_RESET;
      base_q <= bfi_pkg::WORD_RESET;
      field_q <= 22'h00_0000;
    end else begin
      ctrl_q <= ctrl_d;
      src_q <= src_d; // RQ5
      base_q <= base_d; // RQ5
      field_q <= field_d;
    end
  end

  // Execution: flags and result
  always_comb begin
    req_flag_d = req_flag_q;
    ack_d = ack_q;
    result_d = result_q;
    err_d = err_q;
    if (go_run && params_ok) begin
      req_flag_d = 1'b1; // RQ7
      ack_d = 1'b1; // RQ7
      result_d = core_result; // RQ1 RQ10
    end else if (go) begin
      // Refused operands behave as a disabled call and hold the result
      req_flag_d = 1'b0; // RQ8
      ack_d = 1'b0; // RQ8
    end
    // Error is sticky, write-one-to-clear; a new error beats the clear
    if (err_clr) begin
      err_d = 1'b0;
    end
    if (go_run && !params_ok) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_flag_q <= 1'b0;
      ack_q <= 1'b0;
      result_q <= bfi_pkg::WORD_RESET;
      err_q <= 1'b0;
    end else begin
      req_flag_q <= req_flag_d;
      ack_q <= ack_d;
      result_q <= result_d; // RQ6
      err_q <= err_d;
    end
  end

  // Read data goes out combinationally so it is valid in the access cycle
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      prdata = read_word(paddr);
    end
  end

  assign result_word = result_q;
  assign exec_request_flag = req_flag_q;
  assign exec_ack = ack_q;

  // Checks
  logic [31:0] chk_mask;
  logic [31:0] chk_place;
  assign chk_mask = 32'hFFFF_FFFF >> (6'd32 - fld_len);
  assign chk_place = chk_mask << dst_pos[4:0];

  sequence s_good_go;
    go_run && params_ok;
  endsequence

  sequence s_idle_go;
    go_idle || (go_run && !params_ok);
  endsequence

  property p_base_load;
    @(posedge pclk) disable iff (!presetn)
    s_good_go |=> ((result_q & ~$past(chk_place)) == ($past(base_ext) & ~$past(chk_place)));
  endproperty
  a_base_load: assert property (p_base_load) else $error("base bits outside field changed"); // RQ1

  property p_field_src;
    @(posedge pclk) disable iff (!presetn)
    s_good_go |=> (((result_q >> $past(dst_pos[4:0])) & ($past(chk_mask) >> $past(dst_pos[4:0])))
      == ((($past(src_ext) >> $past(src_pos[4:0])) & $past(chk_mask)) &
          ($past(chk_mask) >> $past(dst_pos[4:0]))));
  endproperty
  a_field_src: assert property (p_field_src) else $error("field bits wrong"); // RQ2 RQ3

  property p_no_wrap;
    @(posedge pclk) disable iff (!presetn)
    (s_good_go and (dst_pos + fld_len > 6'd32)) |=>
      ((result_q & ~(32'hFFFF_FFFF << $past(dst_pos[4:0]))) ==
       ($past(base_ext) & ~(32'hFFFF_FFFF << $past(dst_pos[4:0]))));
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("field bits wrapped to low bits"); // RQ4

  property p_operands_kept;
    @(posedge pclk) disable iff (!presetn)
    go |=> ($stable(src_q) && $stable(base_q) && $stable(field_q));
  endproperty
  a_operands_kept: assert property (p_operands_kept) else $error("operand changed by go"); // RQ5

  property p_hold_disabled;
    @(posedge pclk) disable iff (!presetn)
    s_idle_go |=> $stable(result_q) ##1 ($past(go) || $stable(result_q));
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("result moved while disabled"); // RQ6

  property p_flags_set;
    @(posedge pclk) disable iff (!presetn)
    s_good_go |=> (exec_request_flag && exec_ack) ##1
      ($past(go) || (exec_request_flag && exec_ack));
  endproperty
  a_flags_set: assert property (p_flags_set) else $error("flags not set on execution"); // RQ7

  property p_flags_clear;
    @(posedge pclk) disable iff (!presetn)
    go && (phase != bfi_pkg::PH_NORMAL || !ctrl_q[bfi_pkg::CTRL_REQ_BIT]) |=>
      (!exec_request_flag && !exec_ack);
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared"); // RQ8

  property p_zero_fill;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q[bfi_pkg::CTRL_SRCW_LSB +: 2] == 2'(bfi_pkg::WD_8)) |-> (src_ext[31:8] == 24'h00_0000);
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("narrow source not zero-filled"); // RQ9

  property p_result_timing;
    @(posedge pclk) disable iff (!presetn)
    !go ##1 !go |-> $stable(result_q);
  endproperty
  a_result_timing: assert property (p_result_timing) else $error("result moved without go"); // RQ10

  property p_err_sticky;
    @(posedge pclk) disable iff (!presetn)
    (go_run && !params_ok) |=> err_q ##1 (err_q || $past(err_clr));
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag lost"); // RQ2

  property p_err_clear;
    @(posedge pclk) disable iff (!presetn)
    err_clr |=> !err_q;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared"); // RQ2

  property p_refused_flags;
    @(posedge pclk) disable iff (!presetn)
    (go_run && !params_ok) |=> (!exec_request_flag && !exec_ack && $stable(result_q));
  endproperty
  a_refused_flags: assert property (p_refused_flags) else $error("refused call moved state"); // RQ8

  property p_read_idle;
    @(posedge pclk) disable iff (!presetn)
    !rd |-> (prdata == 32'h0000_0000);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside a read");

  property p_result_ro;
    @(posedge pclk) disable iff (!presetn)
    (wr && (paddr == bfi_pkg::OFF_RESULT)) |=> $stable(result_q);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("bus write reached the result");
endmodule

/* rtl/bfi_pkg.sv */
// Constants and types shared by the bit-field insert unit.
// Assumes a 32-bit APB slave interface with byte addresses in paddr.
package bfi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SRC = 8'h04;
  localparam logic [7:0] OFF_BASE = 8'h08;
  localparam logic [7:0] OFF_FIELD = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RESULT = 8'h18;

  // Control register fields
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_INPLACE_BIT = 1;
  localparam int CTRL_PHASE_LSB = 2;
  localparam int CTRL_SRCW_LSB = 4;
  localparam int CTRL_BASEW_LSB = 6;
  localparam int CTRL_W = 8;
  // exec_request defaults to asserted
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // Field register layout
  localparam int FLD_SRCPOS_LSB = 0;
  localparam int FLD_LEN_LSB = 8;
  localparam int FLD_DSTPOS_LSB = 16;
  localparam int FLD_SUB_W = 6;

  // Command and status bits
  localparam int CMD_GO_BIT = 0;
  localparam int STAT_REQ_BIT = 0;
  localparam int STAT_ACK_BIT = 1;
  localparam int STAT_ERR_BIT = 2;

  localparam logic [5:0] POS_MAX = 6'd31;
  localparam logic [5:0] LEN_MIN = 6'd1;
  localparam logic [5:0] LEN_MAX = 6'd32;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    PH_NORMAL,
    PH_PRESCAN,
    PH_POSTSCAN
  } bfi_phase_t;

  typedef enum logic [1:0] {
    WD_32,
    WD_16,
    WD_8
  } bfi_width_t;
endpackage

/* rtl/bfi_field_core.sv */
// Combinational field insert: widen operands, extract, place, merge.
// Assumes positions 0..31 and length 1..32 have been checked upstream.
module bfi_field_core (
  input wire logic [31:0] src_word,
  input wire logic [31:0] base_word,
  input wire logic [1:0] src_width,
  input wire logic [1:0] base_width,
  input wire logic [4:0] src_low_pos,
  input wire logic [4:0] dst_low_pos,
  input wire logic [5:0] field_len,
  output logic [31:0] src_ext,
  output logic [31:0] base_ext,
  output logic [31:0] result
);
  // Zero-fill of narrow words
  function automatic logic [31:0] widen(input logic [31:0] w, input logic [1:0] wd);
    logic [31:0] r;
    r = w;
    case (bfi_pkg::bfi_width_t'(wd))
      bfi_pkg::WD_16: r = {16'h0000, w[15:0]};
      bfi_pkg::WD_8: r = {24'h00_0000, w[7:0]};
      default: r = w;
    endcase
    return r;
  endfunction

  logic [31:0] len_mask;
  logic [31:0] field;
  logic [31:0] place_mask;

  always_comb begin
    src_ext = widen(src_word, src_width); // RQ9
    base_ext = widen(base_word, base_width); // RQ9
    // Shift right of all ones avoids a 33-bit term at length 32
    len_mask = 32'hFFFF_FFFF >> (6'd32 - field_len);
    field = (src_ext >> src_low_pos) & len_mask; // RQ2
    // 32-bit left shifts drop bits past the top, never wrapping
    place_mask = len_mask << dst_low_pos; // RQ3 RQ4
    result = (base_ext & ~place_mask) | ((field << dst_low_pos) & place_mask); // RQ1 RQ4
  end
endmodule

/* verif/bfi_seq_model.sv */
// Sequencer model: an APB master that hands operands and go commands to the unit.
// Assumes an APB slave on pclk that may add wait states through pready.
module bfi_seq_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Starts on a fresh edge so a back-to-back call never assigns a signal twice in one step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Released lines carry junk so a stale value is never mistaken for a live one
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* verif/bfi_top_tb.sv */
// Self-checking bench for the bit-field insert unit.
// Assumes the sequencer model as APB master and a result visible one cycle after go.
module bfi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic exec_request_flag, exec_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, result_word, rd, last;
  int fail_count, checked, cycles;
  logic [7:0] refused [3] = '{8'h00, 8'h05, 8'h09};

  bfi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .result_word(result_word), .exec_request_flag(exec_request_flag),
    .exec_ack(exec_ack));

  bfi_seq_model seq (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Mismatches %0d, comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    seq.xfer(1'h1, a, d, rd, err);
  endtask

  function automatic logic [31:0] wmask(input logic [1:0] w);
    return (w == 2'h1) ? 32'h0000_ffff : (w == 2'h2) ? 32'h0000_00ff : 32'hffff_ffff;
  endfunction

  // Bit-by-bit reference; source bits past 31 read as zero, result bits past 31 are dropped
  function automatic logic [31:0] ref_insert(input logic [31:0] s, input logic [31:0] b,
                                             input int sp, input int len, input int dp);
    logic [31:0] r;
    r = b;
    for (int i = 0; i < len; i++)
      if (dp + i < 32) r[dp + i] = (sp + i < 32) ? s[sp + i] : 1'b0;
    return r;
  endfunction

  // Loads all operands, fires go, then checks result, flags and untouched operands
  task automatic go(input logic [7:0] c, input logic [31:0] s, input logic [31:0] b,
                    input logic [5:0] sp, input logic [5:0] len, input logic [5:0] dp);
    logic en;
    en = c[0] && (c[3:2] == 2'h0);
    // In-place mode takes the current result as its base word
    if (en) last = ref_insert(s & wmask(c[5:4]), (c[1] ? last : b) & wmask(c[7:6]),
                              sp, len, dp);
    wr(bfi_pkg::OFF_CTRL, {24'h00_0000, c});
    wr(bfi_pkg::OFF_SRC, s);
    wr(bfi_pkg::OFF_BASE, b);
    wr(bfi_pkg::OFF_FIELD, {10'h000, dp, 2'h0, len, 2'h0, sp});
    wr(bfi_pkg::OFF_CMD, 32'h0000_0001);
    @(posedge pclk);
    #1;
    check(result_word, last);
    check({30'h0, exec_request_flag, exec_ack}, {30'h0, en, en});
    seq.xfer(1'h0, bfi_pkg::OFF_SRC, 32'h0000_0000, rd, err);
    check(rd, s);
    seq.xfer(1'h0, bfi_pkg::OFF_BASE, 32'h0000_0000, rd, err);
    check(rd, b);
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    presetn = 1'h0;
    last = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    seq.xfer(1'h0, bfi_pkg::OFF_CTRL, 32'h0000_0000, rd, err);
    check(rd, 32'h0000_0001);
    // Operand values stay in the documented ranges
    go(8'h01, 32'hffff_ffff, 32'h0000_0000, 3, 10, 5);
    check(result_word, 32'h0000_7fe0);
    go(8'h01, 32'h1234_5678, 32'ha5a5_a5a5, 4, 32, 20);
    go(8'h01, 32'h8000_0001, 32'hffff_0000, 0, 1, 31);
    go(8'h01, 32'hdead_beef, 32'h0000_0000, 31, 32, 0);
    go(8'h61, 32'hffff_ffab, 32'hffff_ffff, 0, 16, 8);
    go(8'h91, 32'hffff_1234, 32'hffff_ffff, 4, 12, 2);
    go(8'h03, 32'h0000_000f, 32'h0000_0000, 0, 4, 28);
    // Each refused go follows a good one so the flags really have to fall
    foreach (refused[k]) begin
      go(8'h01, 32'h0000_00ff, 32'h0000_0000, 0, 8, 4);
      go(refused[k], 32'h0f0f_0f0f, 32'h3333_3333, 1, 9, 7);
    end
    // Length 0 is refused: flags fall, result holds, error sticks until cleared
    go(8'h01, 32'h0000_00ff, 32'h0000_0000, 0, 8, 4);
    wr(bfi_pkg::OFF_FIELD, 32'h0000_0000);
    wr(bfi_pkg::OFF_CMD, 32'h0000_0001);
    seq.xfer(1'h0, bfi_pkg::OFF_STATUS, 32'h0000_0000, rd, err);
    check(rd, 32'h0000_0004);
    check(result_word, last);
    wr(bfi_pkg::OFF_STATUS, 32'h0000_0004);
    seq.xfer(1'h0, bfi_pkg::OFF_STATUS, 32'h0000_0000, rd, err);
    check(rd, 32'h0000_0000);
    seq.xfer(1'h0, 8'h1c, 32'h0000_0000, rd, err);
    check({err, rd[30:0]}, 32'h8000_0000);
    wr(bfi_pkg::OFF_RESULT, 32'h5555_5555);
    @(posedge pclk);
    check(result_word, last);
    tally_and_finish();
  end
endmodule
